// >>> fcs_pkg.sv
// package: constants, modes, jobs and bus carrier for the flash command sequencer
package fcs_pkg;
  localparam int          FCS_AW           = 20;
  localparam logic [19:0] FCS_ADDR_UNLOCK1 = 20'h04555;
  localparam logic [19:0] FCS_ADDR_UNLOCK2 = 20'h04aaa;
  localparam logic [19:0] FCS_ADDR_VENDOR  = 20'h04000;
  localparam logic [19:0] FCS_ADDR_MACRO   = 20'h04001;
  localparam logic [19:0] FCS_ADDR_SIZE    = 20'h04002;
  localparam logic [19:0] FCS_ADDR_SECST   = 20'h04f7f;
  localparam logic [7:0]  FCS_DAT_UNLOCK1  = 8'haa;
  localparam logic [7:0]  FCS_DAT_UNLOCK2  = 8'h55;
  localparam logic [7:0]  FCS_OP_PROGRAM   = 8'ha0;
  localparam logic [7:0]  FCS_OP_ERASE     = 8'h80;
  localparam logic [7:0]  FCS_OP_ID_ENTRY  = 8'h90;
  localparam logic [7:0]  FCS_OP_ID_EXIT   = 8'hf0;
  localparam logic [7:0]  FCS_OP_SECURITY  = 8'ha5;
  localparam logic [7:0]  FCS_OP_SECTOR    = 8'h30;
  localparam logic [7:0]  FCS_OP_CHIP      = 8'h10;
  localparam logic [7:0]  FCS_DAT_SEC_SET  = 8'h00;
  localparam logic [7:0]  FCS_ERASED       = 8'hff;
  localparam logic [3:0]  FCS_CMD_ENABLE   = 4'h3;
  localparam logic [3:0]  FCS_CMD_LOCKED   = 4'hc;
  localparam int          FCS_TOGGLE_BIT   = 6;
  localparam int          FCS_SECTOR_MSB   = 15;
  localparam int          FCS_SECTOR_LSB   = 12;
  // timing, printed figures and derived cycle counts at 125 MHz
  localparam int          FCS_CLK_MHZ      = 125;
  localparam int          FCS_T_SECTOR_MS  = 30;
  localparam int          FCS_T_CHIP_MS    = 30;
  localparam int          FCS_T_SEC_US     = 40;
  localparam int          FCS_T_PROG_US    = 40;
  localparam int          FCS_CYC_SECTOR   = FCS_T_SECTOR_MS * 1000 * FCS_CLK_MHZ;
  localparam int          FCS_CYC_CHIP     = FCS_T_CHIP_MS * 1000 * FCS_CLK_MHZ;
  localparam int          FCS_CYC_SEC      = FCS_T_SEC_US * FCS_CLK_MHZ;
  localparam int          FCS_CYC_PROG     = FCS_T_PROG_US * FCS_CLK_MHZ;
  localparam int          FCS_TW           = 24;

  typedef enum logic [1:0] {
    FCS_MODE_MCU,
    FCS_MODE_SERIAL,
    FCS_MODE_PARALLEL
  } fcs_mode_t;

  typedef enum logic [2:0] {
    FCS_JOB_NONE,
    FCS_JOB_PROGRAM,
    FCS_JOB_SECTOR,
    FCS_JOB_CHIP,
    FCS_JOB_SECURITY
  } fcs_job_t;

  // one cpu bus cycle towards the flash window
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [19:0] addr;
    logic [7:0]  wdata;
  } fcs_bus_t;

  // request to the array back end
  typedef struct packed {
    fcs_job_t    job;
    logic [19:0] addr;
    logic [7:0]  data;
  } fcs_op_t;
endpackage

// >>> fcs_timer.sv
// busy timer: counts down the duration of one flash operation
`timescale 1ns/10ps
`default_nettype none
module fcs_timer
  import fcs_pkg::*;
#(
  parameter int TW = FCS_TW
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  // control
  input  wire logic          start,
  input  wire logic [TW-1:0] cycles,
  // status
  output logic               busy,
  output logic               done
);
  logic [TW-1:0] count_reg;

  // load on start, then count down to one; done pulses for one cycle as busy falls
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_reg <= cycles;
        busy      <= 1'b1;
      end else if (busy) begin
        if (count_reg <= TW'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count_reg <= count_reg - TW'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> fcs_array.sv
// flash array model: byte storage with program, sector erase and chip erase
`timescale 1ns/10ps
`default_nettype none
module fcs_array
  import fcs_pkg::*;
#(
  parameter int AW = 16
) (
  // clock
  input  wire logic          clk_sys,
  // write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // erase side
  input  wire logic          erase_sector,
  input  wire logic          erase_chip,
  input  wire logic [3:0]    sector,
  // read side
  input  wire logic [AW-1:0] raddr,
  output logic [7:0]         rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  // program only clears bits, as a real cell does; erase sets whole regions
  always_ff @(posedge clk_sys) begin
    // walk the whole array only on an erase pulse, not on every clock
    if (erase_chip || erase_sector) begin
      for (int i = 0; i < (1 << AW); i++) begin
        if (erase_chip || (i[AW-1:AW-4] == sector))
          mem[i] <= FCS_ERASED;
      end
    end
    if (we)
      mem[waddr] <= mem[waddr] & wdata;
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// >>> fcs_top.sv
// flash command sequencer: unlock decoding, busy tracking, toggle polling, id mode
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module fcs_top
  import fcs_pkg::*;
#(
  parameter int          AW          = 16,
  parameter logic [7:0]  VENDOR_CODE = 8'h5a,  // arbitrary value
  parameter logic [7:0]  MACRO_CODE  = 8'h3c,  // arbitrary value
  parameter logic [7:0]  SIZE_CODE   = 8'h01,
  parameter int          CYC_SECTOR  = FCS_CYC_SECTOR,
  parameter int          CYC_CHIP    = FCS_CYC_CHIP,
  parameter int          CYC_SEC     = FCS_CYC_SEC,
  parameter int          CYC_PROG    = FCS_CYC_PROG
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // control register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [3:0]  reg_wdata,
  output logic [3:0]       reg_rdata,
  // cpu bus cycles into the flash window
  input  wire fcs_bus_t    bus,
  output logic [7:0]       bus_rdata,
  // programming mode straps, from pins
  input  wire logic        mode_serial_pin,
  input  wire logic        mode_parallel_pin,
  // serial loader asks to run a flash write or ram loader command
  input  wire logic        serial_cmd_req,
  output logic             serial_cmd_refused,
  // status
  output logic             op_busy,
  output logic             id_mode,
  output logic             secured,
  output logic             parallel_blocked
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_UNLOCK2, ST_OPCODE, ST_ERASE_AA, ST_ERASE_55, ST_ERASE_CMD, ST_DATA
  } fcs_state_t;

  fcs_state_t    state_reg;
  fcs_job_t      job_reg;
  logic [3:0]    enable_reg;
  logic          secure_reg;
  logic          toggle_reg;
  logic          first_rd_reg;
  logic [19:0]   last_addr_reg;
  logic          rd_d_reg;
  logic          id_rd_reg;
  logic [7:0]    id_data_reg;
  logic [1:0]    ser_sync_reg;
  logic [1:0]    par_sync_reg;
  fcs_mode_t     mode;
  logic          start;
  fcs_op_t       op_next;
  fcs_op_t       op_reg;
  logic [FCS_TW-1:0] cycles;
  logic          t_busy;
  logic          t_done;
  logic [7:0]    arr_rdata;
  logic          cmd_ok;

  // match helper for the unlock and opcode steps
  function automatic logic hit(input fcs_bus_t b, input logic [19:0] a, input logic [7:0] d);
    return b.wr && (b.addr == a) && (b.wdata == d);
  endfunction

  // mode pins cross in from outside through two flops each
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ser_sync_reg <= 2'h0;
      par_sync_reg <= 2'h0;
    end else begin
      ser_sync_reg <= {ser_sync_reg[0], mode_serial_pin};
      par_sync_reg <= {par_sync_reg[0], mode_parallel_pin};
    end
  end

  always_comb begin
    if (par_sync_reg[1])
      mode = FCS_MODE_PARALLEL;
    else if (ser_sync_reg[1])
      mode = FCS_MODE_SERIAL;
    else
      mode = FCS_MODE_MCU;
  end

  // command enable field; only the two legal codes are stored
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      enable_reg <= FCS_CMD_LOCKED;
    else if (reg_wr && (reg_wdata == FCS_CMD_ENABLE || reg_wdata == FCS_CMD_LOCKED))
      enable_reg <= reg_wdata;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      reg_rdata <= 4'h0;
    else if (reg_rd)
      reg_rdata <= enable_reg;
    else
      reg_rdata <= 4'h0;
  end

  // sequences run only when unlocked, idle and not under a parallel writer
  // start needs no guard here: one bus write per cycle, and t_busy covers every later one
  assign cmd_ok = (enable_reg == FCS_CMD_ENABLE) && !t_busy
               && (mode != FCS_MODE_PARALLEL);

  // unlock and opcode decoder; reads leave the step untouched
  always_comb begin
    op_next = '{job: FCS_JOB_NONE, addr: bus.addr, data: bus.wdata};
    case (state_reg)
      ST_DATA: begin
        if (bus.wr)
          op_next.job = FCS_JOB_PROGRAM;
      end
      ST_ERASE_CMD: begin
        if (hit(bus, FCS_ADDR_UNLOCK1, FCS_OP_CHIP))
          op_next.job = FCS_JOB_CHIP;
        else if (bus.wr && bus.wdata == FCS_OP_SECTOR && mode != FCS_MODE_PARALLEL)
          op_next.job = FCS_JOB_SECTOR;
      end
      ST_OPCODE: begin
        if (hit(bus, FCS_ADDR_SECST, FCS_DAT_SEC_SET) && job_reg == FCS_JOB_SECURITY)
          op_next.job = FCS_JOB_SECURITY;
      end
      default: op_next.job = FCS_JOB_NONE;
    endcase
  end

  assign start = (op_next.job != FCS_JOB_NONE) && cmd_ok;

  // sequence step machine
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      job_reg   <= FCS_JOB_NONE;
    end else if (bus.wr) begin
      state_reg <= ST_IDLE;
      job_reg   <= FCS_JOB_NONE;
      if (cmd_ok) begin
        case (state_reg)
          ST_IDLE: begin
            if (hit(bus, FCS_ADDR_UNLOCK1, FCS_DAT_UNLOCK1))
              state_reg <= ST_UNLOCK2;
          end
          ST_UNLOCK2: begin
            if (hit(bus, FCS_ADDR_UNLOCK2, FCS_DAT_UNLOCK2))
              state_reg <= ST_OPCODE;
          end
          ST_OPCODE: begin
            if (job_reg == FCS_JOB_NONE) begin
              if (hit(bus, FCS_ADDR_UNLOCK1, FCS_OP_ERASE))
                state_reg <= ST_ERASE_AA;
              else if (hit(bus, FCS_ADDR_UNLOCK1, FCS_OP_PROGRAM))
                state_reg <= ST_DATA;
              else if (hit(bus, FCS_ADDR_UNLOCK1, FCS_OP_SECURITY)) begin
                state_reg <= ST_OPCODE;
                job_reg   <= FCS_JOB_SECURITY;
              end
            end
          end
          ST_ERASE_AA: begin
            if (hit(bus, FCS_ADDR_UNLOCK1, FCS_DAT_UNLOCK1))
              state_reg <= ST_ERASE_55;
          end
          ST_ERASE_55: begin
            if (hit(bus, FCS_ADDR_UNLOCK2, FCS_DAT_UNLOCK2))
              state_reg <= ST_ERASE_CMD;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // id mode entry and exit, including the single-cycle f0 exit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      id_mode <= 1'b0;
    else if (bus.wr && cmd_ok) begin
      if (state_reg == ST_OPCODE && job_reg == FCS_JOB_NONE && hit(bus, FCS_ADDR_UNLOCK1, FCS_OP_ID_ENTRY))
        id_mode <= 1'b1;
      else if (bus.wdata == FCS_OP_ID_EXIT && (state_reg == ST_IDLE || state_reg == ST_OPCODE))
        id_mode <= 1'b0;
    end
  end

  // cycle count per job; sector and security use their worst-case bound
  always_comb begin
    case (op_next.job)
      FCS_JOB_SECTOR:   cycles = FCS_TW'(CYC_SECTOR);
      FCS_JOB_CHIP:     cycles = FCS_TW'(CYC_CHIP);
      FCS_JOB_SECURITY: cycles = FCS_TW'(CYC_SEC);
      default:          cycles = FCS_TW'(CYC_PROG);
    endcase
  end

  fcs_timer #(.TW(FCS_TW)) u_timer (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .start   (start),
    .cycles  (cycles),
    .busy    (t_busy),
    .done    (t_done)
  );

  // latch the accepted operation; its effect lands when the timer ends
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      op_reg <= '{job: FCS_JOB_NONE, addr: 20'h0, data: 8'h0};
    else if (start)
      op_reg <= op_next;
  end

  fcs_array #(.AW(AW)) u_array (
    .clk_sys      (clk_sys),
    .we           (t_done && op_reg.job == FCS_JOB_PROGRAM),
    .waddr        (op_reg.addr[AW-1:0]),
    .wdata        (op_reg.data),
    .erase_sector (t_done && op_reg.job == FCS_JOB_SECTOR),
    .erase_chip   (t_done && op_reg.job == FCS_JOB_CHIP),
    .sector       (op_reg.addr[FCS_SECTOR_MSB:FCS_SECTOR_LSB]),
    .raddr        (bus.addr[AW-1:0]),
    .rdata        (arr_rdata)
  );

  // protection sets at the end of a security job, clears only by chip erase
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      secure_reg <= 1'b0;
    else if (t_done && op_reg.job == FCS_JOB_SECURITY)
      secure_reg <= 1'b1;
    else if (t_done && op_reg.job == FCS_JOB_CHIP)
      secure_reg <= 1'b0;
  end

  // toggle tracking: first read after a start gives 1, then inverts per same-address read
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      toggle_reg    <= 1'b0;
      first_rd_reg  <= 1'b0;
      last_addr_reg <= 20'h0;
    end else if (start) begin
      first_rd_reg <= 1'b1;
    end else if (bus.rd && t_busy) begin
      last_addr_reg <= bus.addr;
      first_rd_reg  <= 1'b0;
      if (first_rd_reg || bus.addr != last_addr_reg)
        toggle_reg <= 1'b1;
      else
        toggle_reg <= ~toggle_reg;
    end
  end

  // id table answer, registered with the read
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_d_reg    <= 1'b0;
      id_rd_reg   <= 1'b0;
      id_data_reg <= 8'h0;
    end else begin
      rd_d_reg  <= bus.rd;
      id_rd_reg <= bus.rd && id_mode;
      case (bus.addr)
        FCS_ADDR_VENDOR: id_data_reg <= VENDOR_CODE;
        FCS_ADDR_MACRO:  id_data_reg <= MACRO_CODE;
        FCS_ADDR_SIZE:   id_data_reg <= SIZE_CODE;
        FCS_ADDR_SECST:  id_data_reg <= secure_reg ? FCS_DAT_SEC_SET : FCS_ERASED;
        default:         id_data_reg <= 8'h0;
      endcase
    end
  end

  // read data mux; array contents are never shown while busy
  always_comb begin
    if (!rd_d_reg)
      bus_rdata = 8'h0;
    else if (op_busy) begin
      bus_rdata = 8'h0;
      bus_rdata[FCS_TOGGLE_BIT] = toggle_reg;
    end else if (id_rd_reg)
      bus_rdata = id_data_reg;
    else if (secured && mode == FCS_MODE_PARALLEL)
      bus_rdata = 8'h0;
    else
      bus_rdata = arr_rdata;
  end

  // registered status outputs
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      op_busy            <= 1'b0;
      secured            <= 1'b0;
      parallel_blocked   <= 1'b0;
      serial_cmd_refused <= 1'b0;
    end else begin
      op_busy            <= t_busy || start;
      secured            <= secure_reg;
      parallel_blocked   <= secure_reg && mode == FCS_MODE_PARALLEL;
      serial_cmd_refused <= serial_cmd_req && secure_reg && mode == FCS_MODE_SERIAL;
    end
  end
endmodule
`default_nettype wire

// >>> fcs_top_assertions.sv
// checker: busy, toggle, protection and register port relations of the sequencer
`timescale 1ns/10ps
`default_nettype none
module fcs_top_assertions
  import fcs_pkg::*;
#(
  parameter int CYC_SECTOR = FCS_CYC_SECTOR,
  parameter int CYC_CHIP   = FCS_CYC_CHIP,
  parameter int CYC_SEC    = FCS_CYC_SEC,
  parameter int CYC_PROG   = FCS_CYC_PROG
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // control register port
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [3:0] reg_wdata,
  input wire logic [3:0] reg_rdata,
  // cpu bus
  input wire fcs_bus_t   bus,
  input wire logic [7:0] bus_rdata,
  // serial loader and status
  input wire logic       serial_cmd_req,
  input wire logic       serial_cmd_refused,
  input wire logic       op_busy,
  input wire logic       id_mode,
  input wire logic       secured,
  input wire logic       parallel_blocked
);
  localparam int M1 = (CYC_SECTOR > CYC_CHIP) ? CYC_SECTOR : CYC_CHIP;
  localparam int M2 = (CYC_SEC > CYC_PROG) ? CYC_SEC : CYC_PROG;
  // longest busy span; one extra cycle for the start edge
  localparam int BUSY_MAX = ((M1 > M2) ? M1 : M2) + 1;
  logic [3:0]  en_q;
  int          busy_cnt;
  logic        rd_d;
  logic        have_last;
  logic        last6;
  logic [19:0] rd_addr;
  logic [19:0] last_addr;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // mirror of the enable field; other codes never stick
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) en_q <= FCS_CMD_LOCKED;
    else if (reg_wr && (reg_wdata == FCS_CMD_ENABLE || reg_wdata == FCS_CMD_LOCKED)) en_q <= reg_wdata;
  end
  // busy span length, so a stuck timer cannot hide
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) busy_cnt <= 0;
    else busy_cnt <= op_busy ? busy_cnt + 1 : 0;
  end
  // toggle bit of the last busy read, forgotten once idle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_d <= 1'b0;
      rd_addr <= '0;
      have_last <= 1'b0;
      last6 <= 1'b0;
      last_addr <= '0;
    end else begin
      rd_d <= bus.rd;
      rd_addr <= bus.addr;
      if (!op_busy) have_last <= 1'b0;
      else if (rd_d) begin
        have_last <= 1'b1;
        last6 <= bus_rdata[6];
        last_addr <= rd_addr;
      end
    end
  end
  busy_bound_a: assert property (op_busy |-> busy_cnt < BUSY_MAX)
    else $error("busy lasted too long");
  start_cause_a: assert property ($rose(op_busy) |-> $past(bus.wr) && en_q == FCS_CMD_ENABLE)
    else $error("operation started without an enabled final write");
  busy_id_a: assert property (op_busy && $past(op_busy) |-> $stable(id_mode))
    else $error("id mode changed while busy");
  toggle_bit_a: assert property (rd_d && op_busy && $past(op_busy) && have_last && rd_addr == last_addr
    |-> bus_rdata[6] != last6)
    else $error("toggle bit did not invert");
  busy_hide_a: assert property (rd_d && op_busy && $past(op_busy) |-> (bus_rdata & 8'hbf) == 8'h00)
    else $error("array data visible while busy");
  secure_set_a: assert property ($rose(secured) |-> $past(op_busy, 2))
    else $error("protection set outside an operation");
  secure_clear_a: assert property ($fell(secured) |-> $past(op_busy) || $past(op_busy, 2))
    else $error("protection cleared outside an erase");
  par_block_a: assert property (parallel_blocked |-> secured)
    else $error("parallel access blocked while unprotected");
  refuse_src_a: assert property (serial_cmd_refused |-> $past(serial_cmd_req) && $past(secured))
    else $error("serial command refused without protection");
  field_read_a: assert property (reg_rd |=> reg_rdata == $past(en_q))
    else $error("enable field read wrong");
  cover property ($rose(op_busy));
  cover property ($rose(id_mode));
  cover property ($fell(secured));
  cover property (serial_cmd_refused);
endmodule
bind fcs_top fcs_top_assertions #(
  .CYC_SECTOR(CYC_SECTOR), .CYC_CHIP(CYC_CHIP), .CYC_SEC(CYC_SEC), .CYC_PROG(CYC_PROG)
) fcs_top_assertions_i (
  .clk_sys(clk_sys), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .bus(bus), .bus_rdata(bus_rdata), .serial_cmd_req(serial_cmd_req),
  .serial_cmd_refused(serial_cmd_refused), .op_busy(op_busy), .id_mode(id_mode), .secured(secured),
  .parallel_blocked(parallel_blocked)
);
`default_nettype wire

// >>> fcs_cpu_model.sv
// cpu model: control program in ram issuing flash bus cycles
`timescale 1ns/10ps
`default_nettype none
module fcs_cpu_model
  import fcs_pkg::*;
(
  // clock
  input  wire logic       clk_sys,
  // bus towards the sequencer
  output fcs_bus_t        bus,
  input  wire logic [7:0] bus_rdata
);
  // idle bus at time zero; caller has masked interrupts before any cycle
  initial bus = '0;
  // one write; released address and data show the inverse so stale values never match
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    bus <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  // one read; data stand only in the cycle after the strobe
  task automatic rd(input logic [19:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    bus <= '{1'b0, 1'b0, ~a, 8'hff};
    #1 d = bus_rdata;
  endtask
  // unlock pair then opcode
  task automatic cmd(input logic [7:0] op);
    wr(FCS_ADDR_UNLOCK1, FCS_DAT_UNLOCK1);
    wr(FCS_ADDR_UNLOCK2, FCS_DAT_UNLOCK2);
    wr(FCS_ADDR_UNLOCK1, op);
  endtask
  // completion poll: same address until two reads agree; n of 100 means no end seen
  task automatic poll(input logic [19:0] a, output logic [7:0] first, output int n);
    logic [7:0] p;
    logic [7:0] q;
    rd(a, first);
    q = first;
    for (n = 1; n < 100; n++) begin
      p = q;
      rd(a, q);
      if (q === p) break;
    end
  endtask
endmodule
`default_nettype wire

// >>> test_flash_command_sequencer.sv
// testbench: command sequences, polling, id mode and protection of the sequencer
`timescale 1ns/10ps
`default_nettype none
module test_flash_command_sequencer;
  import fcs_pkg::*;
  localparam int         CYC  = 20;
  localparam logic [7:0] VEND = 8'h5a; // arbitrary value
  localparam logic [7:0] MACR = 8'h3c; // arbitrary value
  localparam logic [7:0] SIZE = 8'h01;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [3:0] reg_wdata = 4'h0;
  logic       mode_serial_pin = 1'b0;
  logic       mode_parallel_pin = 1'b0;
  logic       serial_cmd_req = 1'b0;
  logic [3:0] reg_rdata;
  logic [7:0] bus_rdata;
  logic [7:0] d;
  logic       serial_cmd_refused, op_busy, id_mode, secured, parallel_blocked;
  fcs_bus_t   bus;
  int         err_count = 0;
  int         checks_done = 0;

  fcs_top #(.VENDOR_CODE(VEND), .MACRO_CODE(MACR), .SIZE_CODE(SIZE), .CYC_SECTOR(CYC), .CYC_CHIP(CYC),
    .CYC_SEC(CYC), .CYC_PROG(CYC)) fcs_top_i (
    .clk_sys(clk_sys), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .bus(bus), .bus_rdata(bus_rdata), .mode_serial_pin(mode_serial_pin),
    .mode_parallel_pin(mode_parallel_pin), .serial_cmd_req(serial_cmd_req),
    .serial_cmd_refused(serial_cmd_refused), .op_busy(op_busy), .id_mode(id_mode), .secured(secured),
    .parallel_blocked(parallel_blocked));
  fcs_cpu_model fcs_cpu_model_i (.clk_sys(clk_sys), .bus(bus), .bus_rdata(bus_rdata));

  always #4 clk_sys = ~clk_sys;

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // field port: one-cycle strobes, read data in the following cycle only
  task automatic reg_write(input logic [3:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(output logic [3:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic erase(input logic [19:0] a, input logic [7:0] last);
    fcs_cpu_model_i.cmd(FCS_OP_ERASE);
    fcs_cpu_model_i.wr(FCS_ADDR_UNLOCK1, FCS_DAT_UNLOCK1);
    fcs_cpu_model_i.wr(FCS_ADDR_UNLOCK2, FCS_DAT_UNLOCK2);
    fcs_cpu_model_i.wr(a, last);
    #1;
  endtask
  // poll to completion; a poll that never settles ends the run
  task automatic wait_done(input logic [19:0] a, output logic [7:0] first);
    int n;
    fcs_cpu_model_i.poll(a, first, n);
    if (n >= 100) begin
      err_count++;
      $display("[ERR] poll expected settled seen toggling");
      summarize();
    end
    chk("toggled before settling", 8'h01, {7'h0, n > 2});
  endtask
  task automatic pins(input logic s, input logic p);
    @(posedge clk_sys);
    mode_serial_pin <= s;
    mode_parallel_pin <= p;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic program_byte(input logic [19:0] a, input logic [7:0] v);
    fcs_cpu_model_i.cmd(FCS_OP_PROGRAM);
    fcs_cpu_model_i.wr(a, v);
    wait_done(a, d);
  endtask

  task automatic t_locked();
    logic [3:0] f;
    reg_read(f);
    chk("field after reset", 8'h0c, {4'h0, f});
    erase(FCS_ADDR_UNLOCK1, FCS_OP_CHIP);
    chk("busy while locked", 8'h00, {7'h0, op_busy});
    reg_write(4'h5);
    reg_write(FCS_CMD_ENABLE);
    reg_read(f);
    chk("field enabled", 8'h03, {4'h0, f});
    $display("test locked done");
  endtask
  task automatic t_chip();
    logic [7:0] first;
    erase(FCS_ADDR_UNLOCK1, FCS_OP_CHIP);
    chk("busy after chip erase", 8'h01, {7'h0, op_busy});
    fcs_cpu_model_i.cmd(FCS_OP_ID_ENTRY);
    wait_done(20'h04000, first);
    chk("first toggle read", 8'h40, first);
    chk("id entry while busy", 8'h00, {7'h0, id_mode});
    fcs_cpu_model_i.rd(20'h04000, d);
    chk("erased low byte", 8'hff, d);
    fcs_cpu_model_i.rd(20'h05eff, d);
    chk("erased high byte", 8'hff, d);
    $display("test chip erase done");
  endtask
  task automatic t_sector();
    program_byte(20'h04010, 8'h12);
    program_byte(20'h05020, 8'h3f);
    fcs_cpu_model_i.rd(20'h05020, d);
    chk("programmed byte", 8'h3f, d);
    erase(20'h05123, FCS_OP_SECTOR);
    chk("busy after sector erase", 8'h01, {7'h0, op_busy});
    wait_done(20'h05020, d);
    fcs_cpu_model_i.rd(20'h05020, d);
    chk("erased sector byte", 8'hff, d);
    fcs_cpu_model_i.rd(20'h04010, d);
    chk("other sector byte", 8'h12, d);
    fcs_cpu_model_i.wr(FCS_ADDR_UNLOCK1, FCS_DAT_UNLOCK1);
    fcs_cpu_model_i.wr(FCS_ADDR_UNLOCK1, FCS_DAT_UNLOCK2);
    fcs_cpu_model_i.wr(FCS_ADDR_UNLOCK1, FCS_OP_ID_ENTRY);
    #1;
    chk("id after bad step", 8'h00, {7'h0, id_mode});
    $display("test program and sector done");
  endtask
  task automatic t_id(input logic [7:0] sec_exp, input logic exit_long);
    fcs_cpu_model_i.cmd(FCS_OP_ID_ENTRY);
    #1;
    chk("id mode entered", 8'h01, {7'h0, id_mode});
    fcs_cpu_model_i.rd(FCS_ADDR_VENDOR, d);
    chk("vendor code", VEND, d);
    fcs_cpu_model_i.rd(FCS_ADDR_MACRO, d);
    chk("macro code", MACR, d);
    fcs_cpu_model_i.rd(FCS_ADDR_SIZE, d);
    chk("size code", SIZE, d);
    fcs_cpu_model_i.rd(FCS_ADDR_SECST, d);
    chk("security status", sec_exp, d);
    if (exit_long) fcs_cpu_model_i.cmd(FCS_OP_ID_EXIT);
    else fcs_cpu_model_i.wr(20'h04000, FCS_OP_ID_EXIT);
    #1;
    chk("id mode left", 8'h00, {7'h0, id_mode});
    $display("test id mode done");
  endtask
  task automatic t_secure();
    fcs_cpu_model_i.cmd(FCS_OP_SECURITY);
    fcs_cpu_model_i.wr(FCS_ADDR_SECST, FCS_DAT_SEC_SET);
    wait_done(FCS_ADDR_SECST, d);
    chk("protection set", 8'h01, {7'h0, secured});
    t_id(8'h00, 1'b1);
    pins(1'b1, 1'b0);
    serial_cmd_req <= 1'b1;
    @(posedge clk_sys);
    serial_cmd_req <= 1'b0;
    #1;
    chk("serial refused", 8'h01, {7'h0, serial_cmd_refused});
    pins(1'b0, 1'b1);
    chk("parallel blocked", 8'h01, {7'h0, parallel_blocked});
    erase(20'h05000, FCS_OP_SECTOR);
    chk("sector erase in parallel", 8'h00, {7'h0, op_busy});
    pins(1'b0, 1'b0);
    erase(20'h05000, FCS_OP_SECTOR);
    wait_done(20'h05000, d);
    chk("kept after sector erase", 8'h01, {7'h0, secured});
    erase(FCS_ADDR_UNLOCK1, FCS_OP_CHIP);
    wait_done(20'h04000, d);
    chk("cleared by chip erase", 8'h00, {7'h0, secured});
    $display("test protection done");
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    t_locked();
    t_chip();
    t_sector();
    t_id(8'hff, 1'b0);
    t_secure();
    reg_write(FCS_CMD_LOCKED);
    summarize();
  end
endmodule
`default_nettype wire
